// *** rtl/flash_host_pkg.sv ***
package flash_host_pkg;
    localparam int addr_w = 18;
    localparam logic [17:0] unlock_addr_a = 18'h05555;
    localparam logic [17:0] unlock_addr_b = 18'h02aaa;
    localparam logic [17:0] lockout_loc = 18'h00002;
    localparam logic [17:0] maker_loc = 18'h00000;
    localparam logic [17:0] part_loc = 18'h00001;
    localparam logic [17:0] boot_last = 18'h01fff;
    localparam logic [7:0] unlock_data_a = 8'haa;
    localparam logic [7:0] unlock_data_b = 8'h55;
    localparam logic [7:0] cmd_setup = 8'h80;
    localparam logic [7:0] cmd_erase = 8'h10;
    localparam logic [7:0] cmd_lockout = 8'h40;
    localparam logic [7:0] cmd_program = 8'ha0;
    localparam logic [7:0] cmd_id_entry = 8'h90;
    localparam logic [7:0] cmd_id_exit = 8'hf0;
    localparam int poll_bit = 7;
    localparam int toggle_bit = 6;
    localparam int lock_bit = 0;
    // bus timing, ns as printed
    localparam int clk_period_ns = 25;
    localparam int write_pulse_ns = 90;
    localparam int write_high_ns = 90;
    localparam int access_ns = 90;
    localparam int float_ns = 25;
    localparam int noise_ns = 15;
    // least times round up
    localparam int write_pulse_cyc = (write_pulse_ns + clk_period_ns - 1) / clk_period_ns;
    localparam int write_high_cyc = (write_high_ns + clk_period_ns - 1) / clk_period_ns;
    localparam int access_cyc = (access_ns + clk_period_ns - 1) / clk_period_ns;
    localparam int float_cyc = (float_ns + clk_period_ns - 1) / clk_period_ns;
    localparam int noise_cyc = (noise_ns + clk_period_ns - 1) / clk_period_ns;
    // host commands
    typedef enum logic [2:0] {
        op_read = 3'h0,
        op_program = 3'h1,
        op_erase = 3'h2,
        op_lockout = 3'h3,
        op_id_entry = 3'h4,
        op_id_exit = 3'h5,
        op_id_exit_short = 3'h6,
        op_raw_write = 3'h7
    } op_t;
endpackage

// *** rtl/flash_cycle_if.sv ***
// one bus cycle request between sequencer and strobe engine
interface flash_cycle_if;
    logic req;
    logic is_write;
    logic [17:0] addr;
    logic [7:0] wdata;
    logic done;
    logic [7:0] rdata;
    modport seq (output req, output is_write, output addr, output wdata, input done, input rdata);
    modport eng (input req, input is_write, input addr, input wdata, output done, output rdata);
endinterface

// *** rtl/flash_cycle_engine.sv ***
// drives one read or write strobe cycle on the flash pins
module flash_cycle_engine (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clk_en,
    flash_cycle_if.eng cyc,
    output logic [17:0] flash_addr,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic [7:0] flash_dq_out,
    output logic flash_dq_oe,
    input wire logic [7:0] flash_dq_in
);
    typedef enum logic [3:0] {
        st_idle = 4'b0001,
        st_strobe = 4'b0010,
        st_recover = 4'b0100,
        st_done = 4'b1000
    } eng_state_t;
    eng_state_t state, next_state;
    logic [7:0] cnt, next_cnt;
    logic [7:0] rdata, next_rdata;
    logic is_write, next_is_write;
    logic [17:0] next_addr;
    logic [7:0] next_dq_out;

    // strobe width always above the noise filter so the device sees it
    localparam logic [7:0] strobe_len = 8'(
        (flash_host_pkg::write_pulse_cyc > flash_host_pkg::access_cyc)
        ? flash_host_pkg::write_pulse_cyc : flash_host_pkg::access_cyc);
    localparam logic [7:0] recover_len = 8'(
        (flash_host_pkg::write_high_cyc > flash_host_pkg::float_cyc)
        ? flash_host_pkg::write_high_cyc : flash_host_pkg::float_cyc);

    // next state of the strobe sequence
    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_rdata = rdata;
        next_is_write = is_write;
        next_addr = flash_addr;
        next_dq_out = flash_dq_out;
        case (state)
            st_idle:
            begin
                if (cyc.req)
                begin
                    next_state = st_strobe;
                    next_cnt = strobe_len;
                    next_is_write = cyc.is_write;
                    next_addr = cyc.addr;
                    next_dq_out = cyc.wdata;
                end
            end
            st_strobe:
            begin
                if (cnt == 8'h01)
                begin
                    next_state = st_recover;
                    next_cnt = recover_len;
                    if (!is_write)
                        next_rdata = flash_dq_in; // sampled before oe rises
                end
                else
                    next_cnt = cnt - 8'h01;
            end
            st_recover:
            begin
                if (cnt == 8'h01)
                    next_state = st_done;
                else
                    next_cnt = cnt - 8'h01;
            end
            st_done: next_state = st_idle;
            default: next_state = st_idle;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            state <= st_idle;
            cnt <= 8'h00;
            rdata <= 8'h00;
            is_write <= 1'b0;
            flash_addr <= 18'h00000;
            flash_dq_out <= 8'h00;
        end
        else if (clk_en)
        begin
            state <= next_state;
            cnt <= next_cnt;
            rdata <= next_rdata;
            is_write <= next_is_write;
            flash_addr <= next_addr;
            flash_dq_out <= next_dq_out;
        end
    end

    // write: oe stays high, ce and we low together; read: we stays high
    always_comb
    begin
        flash_ce_n = (state != st_strobe);
        flash_we_n = !((state == st_strobe) && is_write);
        flash_oe_n = !((state == st_strobe) && !is_write);
        flash_dq_oe = is_write && (state == st_strobe || state == st_recover);
    end
    assign cyc.done = (state == st_done);
    assign cyc.rdata = rdata;

    a_write_oe_high: assert property (@(posedge sys_clk) disable iff (srst)
        !flash_we_n |-> flash_oe_n && !flash_ce_n) else $error("write strobe with oe low");
    a_we_width: assert property (@(posedge sys_clk) disable iff (srst)
        (clk_en && $fell(flash_we_n)) |-> !flash_we_n [*2]) else $error("we pulse too short");
    a_no_contention: assert property (@(posedge sys_clk) disable iff (srst)
        !flash_oe_n |-> !flash_dq_oe) else $error("host drives dq while device reads");
endmodule

// *** rtl/flash_host.sv ***
// host sequencer: turns one command into the documented bus cycles
module flash_host (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire flash_host_pkg::op_t cmd_op,
    input wire logic [17:0] cmd_addr,
    input wire logic [7:0] cmd_data,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_error,
    output logic id_mode,
    output logic [17:0] flash_addr,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic [7:0] flash_dq_out,
    output logic flash_dq_oe,
    input wire logic [7:0] flash_dq_in
);
    typedef enum logic [5:0] {
        st_idle = 6'b000001,
        st_issue = 6'b000010,
        st_wait = 6'b000100,
        st_poll = 6'b001000,
        st_poll_wait = 6'b010000,
        st_reply = 6'b100000
    } seq_state_t;

    flash_cycle_if cyc ();

    seq_state_t state, next_state;
    flash_host_pkg::op_t op, next_op;
    logic [17:0] addr, next_addr;
    logic [7:0] data, next_data;
    logic [2:0] step, next_step;
    logic [7:0] prev_rd, next_prev_rd;
    logic first_poll, next_first_poll;
    logic next_id_mode;
    logic [7:0] next_rsp_data;
    logic next_rsp_error;

    // number of bus cycles per command
    function automatic logic [2:0] seq_len(input flash_host_pkg::op_t o);
        case (o)
            flash_host_pkg::op_program: seq_len = 3'h4;
            flash_host_pkg::op_erase, flash_host_pkg::op_lockout: seq_len = 3'h6;
            flash_host_pkg::op_id_entry, flash_host_pkg::op_id_exit: seq_len = 3'h3;
            default: seq_len = 3'h1;
        endcase
    endfunction

    // address/data of bus cycle n of a command; unlock prefix shared by all multi-cycle commands
    function automatic logic [25:0] seq_word(input flash_host_pkg::op_t o, input logic [2:0] n,
                                             input logic [17:0] a, input logic [7:0] d);
        logic [7:0] last;
        last = flash_host_pkg::cmd_id_exit;
        case (o)
            flash_host_pkg::op_erase: last = flash_host_pkg::cmd_erase;
            flash_host_pkg::op_lockout: last = flash_host_pkg::cmd_lockout;
            flash_host_pkg::op_id_entry: last = flash_host_pkg::cmd_id_entry;
            default: last = flash_host_pkg::cmd_id_exit;
        endcase
        if (o == flash_host_pkg::op_read || o == flash_host_pkg::op_raw_write)
            seq_word = {a, d};
        else if (o == flash_host_pkg::op_id_exit_short)
            seq_word = {a, flash_host_pkg::cmd_id_exit}; // any location
        else if (o == flash_host_pkg::op_program && n == 3'h3)
            seq_word = {a, d}; // program target byte, after the shared unlock prefix
        else if (n == 3'h0 || n == 3'h3)
            seq_word = {flash_host_pkg::unlock_addr_a, flash_host_pkg::unlock_data_a};
        else if (n == 3'h1 || n == 3'h4)
            seq_word = {flash_host_pkg::unlock_addr_b, flash_host_pkg::unlock_data_b};
        else if (n == 3'h2 && o == flash_host_pkg::op_program)
            seq_word = {flash_host_pkg::unlock_addr_a, flash_host_pkg::cmd_program};
        else if (n == 3'h2)
            seq_word = {flash_host_pkg::unlock_addr_a,
                        (o == flash_host_pkg::op_erase || o == flash_host_pkg::op_lockout)
                        ? flash_host_pkg::cmd_setup : last};
        else
            seq_word = {flash_host_pkg::unlock_addr_a, last};
    endfunction

    logic [25:0] word;
    logic is_program_target;
    logic needs_poll;
    assign word = seq_word(op, step, addr, data);
    assign is_program_target = (op == flash_host_pkg::op_program) && (step == 3'h3);
    assign needs_poll = (op == flash_host_pkg::op_program) || (op == flash_host_pkg::op_erase)
                        || (op == flash_host_pkg::op_lockout);

    // the engine sees a request only while issuing or polling
    assign cyc.req = (state == st_issue) || (state == st_poll);
    assign cyc.is_write = (state == st_issue) && (op != flash_host_pkg::op_read);
    assign cyc.addr = (state == st_poll) ? addr : word[25:8];
    assign cyc.wdata = word[7:0];
    assign cmd_ready = (state == st_idle);

    // command sequencing and completion polling
    always_comb
    begin
        next_state = state;
        next_op = op;
        next_addr = addr;
        next_data = data;
        next_step = step;
        next_prev_rd = prev_rd;
        next_first_poll = first_poll;
        next_id_mode = id_mode;
        next_rsp_data = rsp_data;
        next_rsp_error = 1'b0;
        case (state)
            st_idle:
            begin
                if (cmd_valid)
                begin
                    next_state = st_issue;
                    next_op = cmd_op;
                    next_addr = cmd_addr;
                    next_data = cmd_data;
                    next_step = 3'h0;
                end
            end
            st_issue:
                next_state = st_wait;
            st_wait:
            begin
                if (cyc.done)
                begin
                    if (step + 3'h1 < seq_len(op))
                    begin
                        next_step = step + 3'h1;
                        next_state = st_issue;
                    end
                    else if (needs_poll)
                    begin
                        next_state = st_poll;
                        next_first_poll = 1'b1;
                    end
                    else
                    begin
                        next_state = st_reply;
                        next_rsp_data = cyc.rdata;
                        if (op == flash_host_pkg::op_id_entry)
                            next_id_mode = 1'b1;
                        if (op == flash_host_pkg::op_id_exit || op == flash_host_pkg::op_id_exit_short)
                            next_id_mode = 1'b0;
                    end
                end
            end
            st_poll:
                next_state = st_poll_wait;
            st_poll_wait:
            begin
                if (cyc.done)
                begin
                    next_prev_rd = cyc.rdata;
                    next_first_poll = 1'b0;
                    // busy while bit 6 flips between reads steady means finished
                    if (!first_poll
                        && cyc.rdata[flash_host_pkg::toggle_bit] == prev_rd[flash_host_pkg::toggle_bit])
                    begin
                        next_state = st_reply;
                        next_rsp_data = cyc.rdata; // true stored byte
                        // program result may only have cleared bits
                        next_rsp_error = is_program_target_done(op, cyc.rdata, data);
                    end
                    else
                        next_state = st_poll;
                end
            end
            st_reply:
                next_state = st_idle;
            default: next_state = st_idle;
        endcase
    end

    // program verify: a mismatch means a bit stayed or a locked boot byte
    function automatic logic is_program_target_done(input flash_host_pkg::op_t o, input logic [7:0] rd,
                                                    input logic [7:0] wd);
        is_program_target_done = (o == flash_host_pkg::op_program) && (rd != wd);
    endfunction

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            state <= st_idle;
            op <= flash_host_pkg::op_read;
            addr <= 18'h00000;
            data <= 8'h00;
            step <= 3'h0;
            prev_rd <= 8'h00;
            first_poll <= 1'b0;
            id_mode <= 1'b0;
            rsp_data <= 8'h00;
            rsp_error <= 1'b0;
        end
        else if (clk_en)
        begin
            state <= next_state;
            op <= next_op;
            addr <= next_addr;
            data <= next_data;
            step <= next_step;
            prev_rd <= next_prev_rd;
            first_poll <= next_first_poll;
            id_mode <= next_id_mode;
            rsp_data <= next_rsp_data;
            rsp_error <= next_rsp_error;
        end
    end

    assign rsp_valid = (state == st_reply);

    flash_cycle_engine u_engine (
        .sys_clk(sys_clk),
        .srst(srst),
        .clk_en(clk_en),
        .cyc(cyc.eng),
        .flash_addr(flash_addr),
        .flash_ce_n(flash_ce_n),
        .flash_oe_n(flash_oe_n),
        .flash_we_n(flash_we_n),
        .flash_dq_out(flash_dq_out),
        .flash_dq_oe(flash_dq_oe),
        .flash_dq_in(flash_dq_in)
    );

    a_prog_third: assert property (@(posedge sys_clk) disable iff (srst)
        (cyc.req && cyc.is_write && op == flash_host_pkg::op_program && step == 3'h2)
        |-> cyc.addr == flash_host_pkg::unlock_addr_a && cyc.wdata == flash_host_pkg::cmd_program)
        else $error("program command cycle wrong");
    a_erase_last: assert property (@(posedge sys_clk) disable iff (srst)
        (cyc.req && op == flash_host_pkg::op_erase && step == 3'h5 && state == st_issue)
        |-> cyc.wdata == flash_host_pkg::cmd_erase && cyc.addr == flash_host_pkg::unlock_addr_a)
        else $error("erase last cycle wrong");
    a_lock_last: assert property (@(posedge sys_clk) disable iff (srst)
        (cyc.req && op == flash_host_pkg::op_lockout && step == 3'h5 && state == st_issue)
        |-> cyc.wdata == flash_host_pkg::cmd_lockout) else $error("lockout last cycle wrong");
    a_unlock_first: assert property (@(posedge sys_clk) disable iff (srst)
        (state == st_issue && step == 3'h0 && seq_len(op) > 3'h1)
        |-> cyc.addr == flash_host_pkg::unlock_addr_a && cyc.wdata == flash_host_pkg::unlock_data_a)
        else $error("unlock first cycle wrong");
    a_exit_clears: assert property (@(posedge sys_clk) disable iff (srst)
        (clk_en && state == st_wait && cyc.done && op == flash_host_pkg::op_id_exit_short)
        |=> !id_mode) else $error("short exit left id mode set");
    a_poll_reads: assert property (@(posedge sys_clk) disable iff (srst)
        (state == st_poll) |-> !cyc.is_write && cyc.addr == addr) else $error("poll not a read");
    a_prog_target: assert property (@(posedge sys_clk) disable iff (srst)
        (state == st_issue && is_program_target) |-> cyc.addr == addr && cyc.wdata == data)
        else $error("program target cycle wrong");
endmodule

// *** tb/flash_dev_model.sv ***
// behavioural parallel flash: decodes command writes, times program and erase in ns
module flash_dev_model #(
    parameter logic [7:0] maker_code = 8'h3c, // arbitrary value
    parameter logic [7:0] part_code = 8'hc3, // arbitrary value
    parameter int prog_ns = 3000,
    parameter int erase_ns = 20000
) (
    input wire logic [17:0] flash_addr,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic [7:0] host_dq,
    input wire logic host_dq_oe,
    output logic [7:0] dq_seen,
    output int writes
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [0:262143];
    logic [17:0] wa;
    logic [7:0] poll_d = 8'hff;
    logic [7:0] rd_val;
    logic [7:0] last_rd = 8'h00;
    logic busy = 1'b0;
    logic tog = 1'b0;
    logic id_on = 1'b0;
    logic locked = 1'b0;
    int step = 0;
    realtime t0 = 0.0;
    wire wr = !flash_ce_n && !flash_we_n && flash_oe_n;
    wire rd = !flash_ce_n && !flash_oe_n && flash_we_n;

    initial
    begin
        writes = 0;
        for (int i = 0; i < 262144; i++) mem[i] = 8'hff;
    end

    // fork so the write process is never stalled by the busy time
    task automatic start_busy(input int t);
        busy = 1'b1;
        fork
            #(t) busy = 1'b0;
        join_none
    endtask

    // any off-pattern write drops the partial sequence
    task automatic take_write(input logic [17:0] a, input logic [7:0] d);
        int nx;
        logic hit_a;
        logic hit_b;
        nx = 0;
        hit_a = (a == 18'h05555);
        hit_b = (a == 18'h02aaa);
        if (step == 3)
        begin
            if (!(locked && a <= 18'h01fff))
                mem[a] = mem[a] & d;
            poll_d = d;
            start_busy(prog_ns);
        end
        else if (hit_a && d == 8'haa && (step == 0 || step == 4))
            nx = step + 1;
        else if (hit_b && d == 8'h55 && (step == 1 || step == 5))
            nx = step + 1;
        else if (hit_a && step == 2)
        begin
            if (d == 8'ha0)
                nx = 3;
            if (d == 8'h80)
                nx = 4;
            if (d == 8'h90)
                id_on = 1'b1;
            if (d == 8'hf0)
                id_on = 1'b0;
        end
        else if (hit_a && step == 6 && (d == 8'h10 || d == 8'h40))
        begin
            if (d == 8'h40)
                locked = 1'b1;
            else
                for (int i = 0; i < 262144; i++) if (!(locked && i < 8192)) mem[i] = 8'hff;
            poll_d = 8'hff;
            start_busy(d == 8'h10 ? erase_ns : prog_ns);
        end
        else if (d == 8'hf0)
            id_on = 1'b0;
        step = nx;
    endtask

    // address taken as the strobe opens
    always @(posedge wr)
    begin
        wa = flash_addr;
        t0 = $realtime;
    end

    // data taken as the strobe closes; glitches under the filter width never count
    always @(negedge wr)
    begin
        if ($realtime - t0 >= 15.0 && !busy)
        begin
            writes++;
            take_write(wa, host_dq);
        end
    end

    // each read opening flips the progress bit while busy
    always @(posedge rd)
        if (busy)
            tog = ~tog;

    always @(negedge rd)
        last_rd = rd_val;

    // read data selection
    always @*
    begin
        if (busy)
            rd_val = {~poll_d[7], tog, mem[flash_addr][5:0]};
        else if (id_on && flash_addr == 18'h00000)
            rd_val = maker_code;
        else if (id_on && flash_addr == 18'h00001)
            rd_val = part_code;
        else if (id_on && flash_addr == 18'h00002)
            rd_val = {7'h00, locked};
        else
            rd_val = mem[flash_addr];
    end

    // released lines show the inverse of the last byte, never a held copy
    assign dq_seen = rd ? rd_val : (host_dq_oe ? host_dq : ~last_rd);
endmodule

// *** tb/parallel_flash_command_status_bench.sv ***
module parallel_flash_command_status_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] maker = 8'h3c; // arbitrary value
    localparam logic [7:0] part = 8'hc3; // arbitrary value
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic clk_en = 1'b1;
    logic cmd_valid = 1'b0;
    flash_host_pkg::op_t cmd_op = flash_host_pkg::op_read;
    logic [17:0] cmd_addr = 18'h00000;
    logic [7:0] cmd_data = 8'h00;
    logic cmd_ready, rsp_valid, rsp_error, id_mode, flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe;
    logic [7:0] rsp_data, flash_dq_out, flash_dq_in, rd;
    logic [17:0] flash_addr;
    logic er;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    int writes, w0;

    flash_host uut (.sys_clk(sys_clk), .srst(srst), .clk_en(clk_en), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_error(rsp_error), .id_mode(id_mode),
        .flash_addr(flash_addr), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
        .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in));

    flash_dev_model #(.maker_code(maker), .part_code(part)) dev (.flash_addr(flash_addr),
        .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .host_dq(flash_dq_out),
        .host_dq_oe(flash_dq_oe), .dq_seen(flash_dq_in), .writes(writes));

    always #12.5 sys_clk = ~sys_clk;

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp, input string what);
        check_byte({7'h00, got}, {7'h00, exp}, what);
    endtask

    task automatic check_count(input int got, input int exp, input string what);
        checks_done++;
        if (got != exp)
        begin
            mismatches++;
            $display("unexpected at %0t: %s count %0d want %0d", $time, what, got, exp);
        end
    endtask

    // one command, held until taken, then the single-cycle answer caught at mid-cycle
    task automatic run_cmd(input flash_host_pkg::op_t op, input logic [17:0] a, input logic [7:0] d);
        int n;
        n = 0;
        w0 = writes;
        @(posedge sys_clk);
        cmd_op <= op;
        cmd_addr <= a;
        cmd_data <= d;
        cmd_valid <= 1'b1;
        @(negedge sys_clk);
        while (cmd_ready !== 1'b1) @(negedge sys_clk);
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        @(negedge sys_clk);
        while (rsp_valid !== 1'b1 && n < 5000)
        begin
            @(negedge sys_clk);
            n++;
        end
        check_flag(rsp_valid, 1'b1, "answer");
        rd = rsp_data;
        er = rsp_error;
    endtask

    task automatic t_read;
        run_cmd(flash_host_pkg::op_read, 18'h12345, 8'h00);
        check_byte(rd, 8'hff, "erased read");
        check_flag(id_mode, 1'b0, "mode after reset");
        $display("test read done");
    endtask

    task automatic t_program;
        run_cmd(flash_host_pkg::op_program, 18'h03000, 8'h5a);
        check_count(writes - w0, 4, "program writes");
        check_byte(rd, 8'h5a, "final poll");
        check_flag(er, 1'b0, "program ok");
        run_cmd(flash_host_pkg::op_read, 18'h03000, 8'h00);
        check_byte(rd, 8'h5a, "readback");
        run_cmd(flash_host_pkg::op_program, 18'h03000, 8'hf0);
        check_flag(er, 1'b1, "zero to one refused");
        run_cmd(flash_host_pkg::op_read, 18'h03000, 8'h00);
        check_byte(rd, 8'h50, "bits only cleared");
        $display("test program done");
    endtask

    task automatic t_id;
        run_cmd(flash_host_pkg::op_id_entry, 18'h00000, 8'h00);
        check_count(writes - w0, 3, "entry writes");
        check_flag(id_mode, 1'b1, "in id mode");
        run_cmd(flash_host_pkg::op_read, 18'h00000, 8'h00);
        check_byte(rd, maker, "maker code");
        run_cmd(flash_host_pkg::op_read, 18'h00001, 8'h00);
        check_byte(rd, part, "part code");
        run_cmd(flash_host_pkg::op_read, 18'h00002, 8'h00);
        check_flag(rd[0], 1'b0, "unlocked status");
        run_cmd(flash_host_pkg::op_id_exit, 18'h00000, 8'h00);
        check_count(writes - w0, 3, "exit writes");
        check_flag(id_mode, 1'b0, "left id mode");
        run_cmd(flash_host_pkg::op_read, 18'h00000, 8'h00);
        check_byte(rd, 8'hff, "array again");
        $display("test id done");
    endtask

    task automatic t_broken;
        run_cmd(flash_host_pkg::op_raw_write, 18'h05555, 8'haa);
        run_cmd(flash_host_pkg::op_raw_write, 18'h02aaa, 8'h55);
        run_cmd(flash_host_pkg::op_raw_write, 18'h05555, 8'h33);
        run_cmd(flash_host_pkg::op_raw_write, 18'h04000, 8'h00);
        run_cmd(flash_host_pkg::op_read, 18'h04000, 8'h00);
        check_byte(rd, 8'hff, "broken sequence");
        $display("test broken done");
    endtask

    task automatic t_lock;
        run_cmd(flash_host_pkg::op_program, 18'h01fff, 8'h11);
        check_flag(er, 1'b0, "boot program");
        run_cmd(flash_host_pkg::op_lockout, 18'h00000, 8'h00);
        check_count(writes - w0, 6, "lockout writes");
        run_cmd(flash_host_pkg::op_id_entry, 18'h00000, 8'h00);
        run_cmd(flash_host_pkg::op_read, 18'h00002, 8'h00);
        check_flag(rd[0], 1'b1, "locked status");
        run_cmd(flash_host_pkg::op_id_exit_short, 18'h01234, 8'h00);
        check_count(writes - w0, 1, "short exit writes");
        check_flag(id_mode, 1'b0, "short exit mode");
        run_cmd(flash_host_pkg::op_read, 18'h00000, 8'h00);
        check_byte(rd, 8'hff, "short exit array");
        run_cmd(flash_host_pkg::op_program, 18'h00100, 8'h00);
        check_flag(er, 1'b1, "locked program");
        run_cmd(flash_host_pkg::op_program, 18'h02000, 8'h00);
        check_flag(er, 1'b0, "above boot sector");
        run_cmd(flash_host_pkg::op_erase, 18'h00000, 8'h00);
        check_count(writes - w0, 6, "erase writes");
        run_cmd(flash_host_pkg::op_read, 18'h01fff, 8'h00);
        check_byte(rd, 8'h11, "boot kept");
        run_cmd(flash_host_pkg::op_read, 18'h02000, 8'h00);
        check_byte(rd, 8'hff, "main erased");
        $display("test lockout done");
    endtask

    // frozen clock enable must hold an offered command off
    task automatic t_freeze;
        @(posedge sys_clk);
        clk_en <= 1'b0;
        cmd_op <= flash_host_pkg::op_read;
        cmd_valid <= 1'b1;
        repeat (8) @(negedge sys_clk);
        check_flag(flash_oe_n, 1'b1, "frozen strobe");
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        clk_en <= 1'b1;
        run_cmd(flash_host_pkg::op_read, 18'h03000, 8'h00);
        check_byte(rd, 8'h50, "after freeze");
        $display("test freeze done");
    endtask

    // a hang is cut short well above the expected few thousand cycles
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            mismatches++;
            $display("unexpected at %0t: run too long", $time);
            wrap_up();
        end
    end

    initial
    begin
        repeat (20) @(posedge sys_clk);
        srst <= 1'b0;
        t_read();
        t_program();
        t_freeze();
        t_id();
        t_broken();
        t_lock();
        wrap_up();
    end
endmodule
